// *** shared/wdog_pkg.sv ***
// package: register map, field layout and timing constants of the windowed watchdog
package wdog_pkg;
    localparam int          ADDR_W          = 8;
    // printed offsets 0x3C and 0x3F are not all multiples of four: they are indices
    localparam logic [7:0]  IDX_CONTROL     = 8'h3C;
    localparam logic [7:0]  IDX_RESTART     = 8'h3F;
    localparam logic [7:0]  IDX_TEST0       = 8'h40;
    localparam logic [7:0]  IDX_TEST1       = 8'h41;
    localparam logic [7:0]  IDX_STATUS      = 8'h42;
    localparam int          BIT_WINDOW      = 7;
    localparam int          BIT_DBGSTOP     = 6;
    localparam int          BIT_WMASK       = 5;
    localparam int          RATE_HI         = 2;
    localparam logic [2:0]  RATE_OFF        = 3'h0;
    localparam logic [2:0]  RATE_LONGEST    = 3'h7;
    localparam logic [7:0]  KEY_ARM         = 8'h55;
    localparam logic [7:0]  KEY_FIRE        = 8'hAA;
    localparam logic [7:0]  READ_ZERO       = 8'h00;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    localparam int          CNT_W           = 24;
    localparam int          CLK_MHZ         = 200;
    localparam int          RESET_PULSE_NS  = 100;
    localparam int          RESET_PULSE_CYC = (RESET_PULSE_NS * CLK_MHZ) / 1000;
    localparam int          PULSE_W         = 8;
    // period exponents for rate codes 1..7
    function automatic logic [4:0] rateExp(input logic [2:0] r);
        unique case (r)
            3'h1: rateExp = 5'h0E;
            3'h2: rateExp = 5'h10;
            3'h3: rateExp = 5'h12;
            3'h4: rateExp = 5'h14;
            3'h5: rateExp = 5'h16;
            3'h6: rateExp = 5'h17;
            3'h7: rateExp = 5'h18;
            default: rateExp = 5'h18;
        endcase
    endfunction : rateExp
endpackage : wdog_pkg

// *** rtl/wdog_axil_slave.sv ***
// AXI4-Lite slave that turns bus cycles into single-cycle register strobes
`timescale 1ns/10ps
module wdog_axil_slave (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic [9:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [9:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             wrStb,
    output logic [7:0]       wrIdx,
    output logic [7:0]       wrData,
    output logic             rdStb,
    output logic [7:0]       rdIdx,
    input  wire logic [7:0]  rdData,
    input  wire logic        rdHit,
    input  wire logic        wrHit
);
    logic       awHave_q;
    logic       wHave_q;
    logic [7:0] awIdx_q;
    logic [7:0] wByte_q;
    logic       wLane_q;
    logic       rdPend_q;

    wire awTake = s_axi_awvalid && s_axi_awready;
    wire wTake  = s_axi_wvalid && s_axi_wready;
    wire arTake = s_axi_arvalid && s_axi_arready;
    wire doWrite = awHave_q && wHave_q && !s_axi_bvalid;

    // next-state views so that the ready outputs can come from flops
    wire awHave_d = (awHave_q || awTake) && !doWrite;
    wire wHave_d  = (wHave_q || wTake) && !doWrite;
    wire bvalid_d = doWrite || (s_axi_bvalid && !s_axi_bready);
    wire rdPend_d = arTake;
    wire rvalid_d = rdPend_q || (s_axi_rvalid && !s_axi_rready);
    assign wrIdx  = awIdx_q;
    assign wrData = wByte_q;
    assign wrStb  = doWrite && wLane_q && wrHit;
    assign rdStb  = rdPend_q;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awIdx_q <= 8'h00;
            wByte_q <= 8'h00;
            wLane_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= wdog_pkg::RESP_OKAY;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !awHave_d && !bvalid_d;
            s_axi_wready <= !wHave_d && !bvalid_d;
            if (awTake) begin
                awHave_q <= 1'b1;
                awIdx_q <= s_axi_awaddr[9:2];
            end
            if (wTake) begin
                wHave_q <= 1'b1;
                wByte_q <= s_axi_wdata[7:0];
                wLane_q <= s_axi_wstrb[0];
            end
            if (doWrite) begin
                awHave_q <= 1'b0;
                wHave_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit ? wdog_pkg::RESP_OKAY : wdog_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rdPend_q <= 1'b0;
            rdIdx <= 8'h00;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= wdog_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !rdPend_d && !rvalid_d;
            if (arTake) begin
                rdPend_q <= 1'b1;
                rdIdx <= s_axi_araddr[9:2];
            end
            if (rdPend_q) begin
                rdPend_q <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, rdData};
                s_axi_rresp <= rdHit ? wdog_pkg::RESP_OKAY : wdog_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : wdog_axil_slave

// *** rtl/wdog_tick_sync.sv ***
// selects the watchdog count source, synchronises it and emits one enable per rising edge
`timescale 1ns/10ps
module wdog_tick_sync (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic internalRcClk,
    input  wire logic crystalOscClk,
    input  wire logic watchdogClkSel,
    output logic      countTick,
    output logic      selChanged
);
    logic srcRaw;
    logic sync1_q;
    logic sync2_q;
    logic last_q;
    logic selLast_q;

    assign srcRaw = watchdogClkSel ? crystalOscClk : internalRcClk;
    assign countTick = sync2_q && !last_q;
    assign selChanged = watchdogClkSel != selLast_q;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            last_q <= 1'b0;
            selLast_q <= 1'b0;
        end else begin
            sync1_q <= srcRaw;
            sync2_q <= sync1_q;
            last_q <= sync2_q;
            selLast_q <= watchdogClkSel;
        end
    end
endmodule : wdog_tick_sync

// *** rtl/windowed_watchdog_arm_logic.sv ***
// windowed watchdog: control register, restart-key check, period counter and reset generation
//
// Contract
// (R1) window mode: key writes only in last quarter of period; earlier ones force reset
// (R2) repeated 0x55 allowed; 0xAA after a 0x55 restarts the period
// (R3) debug-stop bit 6 set halts watchdog and tick counters in debug mode
// (R4) mask bit 5 set keeps window and rate, and spends no write-once
// (R5) nonzero rate write enables the counter and starts a new period
// (R6) period expiry without restart asserts system reset
// (R7) enabled, debug active, stop bit clear, special mode: longest period, no window
// (R8) rate codes 1..7 select 2^14,16,18,20,22,23,24 count cycles; 0 disables
// (R9) restart register reads 0x00 and accepts writes anytime
// (R10) rate 000: restart-register writes are ignored
// (R11) enabled: any key other than 0x55 or 0xAA forces reset at once
// (R12) software completes the key pair before the period expires
// (R13) factory test registers writable only in special mode, readable always
// (R14) mask clear: window and rate writable anytime in special, once in normal
// (R15) debug-stop set-only in normal mode; 0-to-1 change restarts the period
// (R16) in special mode every control write restarts the period
// (R17) clock select picks crystal or RC source; changing it restarts the period
// (R18) each restart clears the period counter to zero
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
module windowed_watchdog_arm_logic #(
    parameter logic [7:0] TEST0_RESET = 8'h00,
    parameter logic [7:0] TEST1_RESET = 8'h00
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic [9:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [9:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        specialMode,
    input  wire logic        debugActive,
    input  wire logic        internalRcClk,
    input  wire logic        crystalOscClk,
    input  wire logic        watchdogClkSel,
    output logic             systemReset,
    output logic             tickTimerHalt
);
    typedef enum logic [1:0] {IDLE, ARMED} key_state_t;

    key_state_t        keyState_q;
    key_state_t        keyState_d;
    logic              window_q;
    logic              dbgStop_q;
    logic [2:0]        rate_q;
    logic              onceUsed_q;
    logic [7:0]        test0_q;
    logic [7:0]        test1_q;
    logic [wdog_pkg::CNT_W:0] count_q;
    logic [wdog_pkg::CNT_W:0] count_d;
    logic [wdog_pkg::PULSE_W-1:0] pulse_q;
    logic              fault_q;

    logic              wrStb;
    logic [7:0]        wrIdx;
    logic [7:0]        wrData;
    logic [7:0]        rdIdx;
    logic [7:0]        rdData;
    logic              rdHit;
    logic              wrHit;
    logic              countTick;
    logic              selChanged;

    wdog_axil_slave u_bus (
        .sys_clk       (sys_clk),
        .reset         (reset),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wrStb         (wrStb),
        .wrIdx         (wrIdx),
        .wrData        (wrData),
        .rdStb         (),
        .rdIdx         (rdIdx),
        .rdData        (rdData),
        .rdHit         (rdHit),
        .wrHit         (wrHit)
    );

    wdog_tick_sync u_tick (
        .sys_clk        (sys_clk),
        .reset          (reset),
        .internalRcClk  (internalRcClk),
        .crystalOscClk  (crystalOscClk),
        .watchdogClkSel (watchdogClkSel), // R17
        .countTick      (countTick),
        .selChanged     (selChanged)
    );

    // register decode
    wire hitCtrl  = wrIdx == wdog_pkg::IDX_CONTROL;
    wire hitKey   = wrIdx == wdog_pkg::IDX_RESTART;
    wire hitTest0 = wrIdx == wdog_pkg::IDX_TEST0;
    wire hitTest1 = wrIdx == wdog_pkg::IDX_TEST1;
    assign wrHit = hitCtrl || hitKey || hitTest0 || hitTest1;
    assign rdHit = (rdIdx == wdog_pkg::IDX_CONTROL) || (rdIdx == wdog_pkg::IDX_RESTART)
                || (rdIdx == wdog_pkg::IDX_TEST0) || (rdIdx == wdog_pkg::IDX_TEST1)
                || (rdIdx == wdog_pkg::IDX_STATUS);

    wire enabled = rate_q != wdog_pkg::RATE_OFF;
    wire [7:0] ctrlView = {window_q, dbgStop_q, 1'b0, 2'b00, rate_q};
    wire [7:0] statusView = {5'h00, fault_q, keyState_q == ARMED, enabled};
    assign rdData = (rdIdx == wdog_pkg::IDX_CONTROL) ? ctrlView :
                    (rdIdx == wdog_pkg::IDX_TEST0)   ? test0_q :
                    (rdIdx == wdog_pkg::IDX_TEST1)   ? test1_q :
                    (rdIdx == wdog_pkg::IDX_STATUS)  ? statusView :
                    wdog_pkg::READ_ZERO; // R9

    // control write qualification
    wire ctrlWr    = wrStb && hitCtrl;
    wire maskBit   = wrData[wdog_pkg::BIT_WMASK];
    wire fieldWr   = ctrlWr && !maskBit && (specialMode || !onceUsed_q); // R4 R14
    wire [2:0] newRate = wrData[wdog_pkg::RATE_HI:0];
    wire newWin    = wrData[wdog_pkg::BIT_WINDOW];
    wire newDbg    = wrData[wdog_pkg::BIT_DBGSTOP];
    // in normal mode writing 000 or window-off leaves the field alone
    wire [2:0] rate_d = !fieldWr ? rate_q :
                        (specialMode || newRate != wdog_pkg::RATE_OFF) ? newRate : rate_q; // R14
    wire win_d  = !fieldWr ? window_q : (specialMode ? newWin : (window_q | newWin)); // R14
    wire dbg_d  = !ctrlWr ? dbgStop_q : (specialMode ? newDbg : (dbgStop_q | newDbg)); // R15

    // override and halt
    wire override = enabled && debugActive && !dbgStop_q && specialMode; // R7
    wire halted   = debugActive && dbgStop_q; // R3
    wire [2:0] effRate = override ? wdog_pkg::RATE_LONGEST : rate_q; // R7
    wire effWin   = window_q && !override; // R7
    wire [4:0] expo = wdog_pkg::rateExp(effRate); // R8
    wire [wdog_pkg::CNT_W:0] period = (wdog_pkg::CNT_W+1)'(1) << expo;
    wire [wdog_pkg::CNT_W:0] winStart = period - (period >> 2); // R1
    wire inWindow = count_q >= winStart;

    // restart sources
    wire ctrlRestart = ctrlWr && (specialMode // R16
                       || (fieldWr && newRate != wdog_pkg::RATE_OFF) // R5
                       || (fieldWr && newWin) // R14
                       || (!dbgStop_q && dbg_d)); // R15
    wire keyWr     = wrStb && hitKey && enabled; // R10
    wire keyBadVal = keyWr && wrData != wdog_pkg::KEY_ARM && wrData != wdog_pkg::KEY_FIRE; // R11
    wire keyEarly  = keyWr && effWin && !inWindow; // R1
    wire keyFire   = keyWr && wrData == wdog_pkg::KEY_FIRE && keyState_q == ARMED && !keyEarly; // R2
    wire expired   = enabled && !halted && countTick && (count_q + 1'b1) >= period; // R6
    wire restart   = ctrlRestart || keyFire || selChanged; // R17
    wire trip      = keyBadVal || keyEarly || expired;

    always_comb begin
        keyState_d = keyState_q;
        if (restart || !enabled) begin
            keyState_d = IDLE;
        end else if (keyWr && wrData == wdog_pkg::KEY_ARM) begin
            keyState_d = ARMED; // R2
        end
    end

    always_comb begin
        count_d = count_q;
        if (restart || !enabled) begin
            count_d = '0; // R18
        end else if (countTick && !halted) begin
            count_d = count_q + 1'b1; // R3
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rate_q <= wdog_pkg::RATE_OFF;
            window_q <= 1'b0;
            dbgStop_q <= 1'b0;
            onceUsed_q <= 1'b0;
        end else begin
            rate_q <= rate_d;
            window_q <= win_d;
            dbgStop_q <= dbg_d;
            if (fieldWr) begin
                onceUsed_q <= 1'b1; // R14
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            test0_q <= TEST0_RESET;
            test1_q <= TEST1_RESET;
        end else if (wrStb && specialMode) begin
            if (hitTest0) test0_q <= wrData; // R13
            if (hitTest1) test1_q <= wrData; // R13
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            keyState_q <= IDLE;
            count_q <= '0;
        end else begin
            keyState_q <= keyState_d;
            count_q <= count_d;
        end
    end

    // reset pulse stretch; the tripped flag survives until bus reset
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pulse_q <= '0;
            systemReset <= 1'b0;
            fault_q <= 1'b0;
            tickTimerHalt <= 1'b0;
        end else begin
            tickTimerHalt <= halted; // R3
            if (trip) begin
                pulse_q <= wdog_pkg::PULSE_W'(wdog_pkg::RESET_PULSE_CYC);
                systemReset <= 1'b1; // R6 R11
                fault_q <= 1'b1;
            end else if (pulse_q != '0) begin
                pulse_q <= pulse_q - 1'b1;
                systemReset <= pulse_q != 8'h01;
            end else begin
                systemReset <= 1'b0;
            end
        end
    end
endmodule : windowed_watchdog_arm_logic

// *** bench/wdog_chk.sv ***
// port-level assertions for the windowed watchdog
`timescale 1ns/10ps
module wdog_chk (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic [9:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic [9:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        specialMode,
    input wire logic        debugActive,
    input wire logic        systemReset,
    input wire logic        tickTimerHalt
);
    localparam logic [9:0] A_CTL = {wdog_pkg::IDX_CONTROL, 2'h0};
    localparam logic [9:0] A_KEY = {wdog_pkg::IDX_RESTART, 2'h0};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic [2:0] rate_q;
    logic       win_q, dbg_q, once_q;
    wire        wrNow  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire        ctlWr  = wrNow && s_axi_awaddr == A_CTL;
    wire        keyWr  = wrNow && s_axi_awaddr == A_KEY;
    wire [7:0]  wd     = s_axi_wdata[7:0];
    wire        arNow  = s_axi_arvalid && s_axi_arready;
    wire        wrOpen = !wd[5] && (specialMode || !once_q);
    // shadow of the control fields, kept with the write-once and mask behaviour
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            {rate_q, win_q, dbg_q, once_q} <= '0;
        end else if (ctlWr) begin
            dbg_q <= specialMode ? wd[6] : (dbg_q | wd[6]);
            if (wrOpen) begin
                once_q <= 1'b1;
                rate_q <= (specialMode || wd[2:0] != 3'h0) ? wd[2:0] : rate_q;
                win_q  <= specialMode ? wd[7] : (win_q | wd[7]);
            end
        end
    end
    property p_pulse; $rose(systemReset) |-> ##19 systemReset ##1 !systemReset; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse length wrong");
    // the shadow leads the design's stop bit by one cycle
    property p_halt; tickTimerHalt == ($past(debugActive) && $past(dbg_q, 2)); endproperty
    a_halt: assert property (p_halt) else $error("tick halt wrong");
    property p_keyrd; arNow && s_axi_araddr == A_KEY |-> ##2 s_axi_rvalid && s_axi_rdata == 32'h0; endproperty
    a_keyrd: assert property (p_keyrd) else $error("key read not zero");
    property p_keywr; keyWr |-> ##2 s_axi_bvalid && s_axi_bresp == wdog_pkg::RESP_OKAY; endproperty
    a_keywr: assert property (p_keywr) else $error("key write refused");
    property p_testrd; arNow && s_axi_araddr[9:3] == 7'h20 |-> ##2 s_axi_rresp == wdog_pkg::RESP_OKAY; endproperty
    a_testrd: assert property (p_testrd) else $error("test read refused");
    property p_ctlrd;
        arNow && s_axi_araddr == A_CTL |-> ##2 s_axi_rdata[7:0] == {win_q, dbg_q, 3'h0, rate_q};
    endproperty
    a_ctlrd: assert property (p_ctlrd) else $error("control read wrong");
    property p_badkey; keyWr && rate_q != 3'h0 && wd != 8'h55 && wd != 8'hAA |-> ##[1:3] systemReset; endproperty
    a_badkey: assert property (p_badkey) else $error("bad key did not trip");
    property p_offkey; keyWr && rate_q == 3'h0 && !systemReset |=> !systemReset [*3]; endproperty
    a_offkey: assert property (p_offkey) else $error("disabled key tripped");
endmodule : wdog_chk

// *** bench/test_windowed_watchdog_arm_logic.sv ***
// self-checking bench for the windowed watchdog
`timescale 1ns/10ps
module test_windowed_watchdog_arm_logic;
    localparam logic [9:0] A_CTL = {wdog_pkg::IDX_CONTROL, 2'h0};
    localparam logic [9:0] A_KEY = {wdog_pkg::IDX_RESTART, 2'h0};
    localparam logic [9:0] A_T0  = {wdog_pkg::IDX_TEST0, 2'h0};
    localparam logic [9:0] A_ST  = {wdog_pkg::IDX_STATUS, 2'h0};
    localparam int         PER1  = 16384;
    logic        sys_clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, srcOn;
    logic        specialMode, debugActive, internalRcClk, crystalOscClk, watchdogClkSel;
    logic        systemReset, tickTimerHalt, mOnce;
    logic [9:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdV, rv;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [7:0]  mCtl;
    int          error_cnt, compares, cyc, seed, ticks;
    windowed_watchdog_arm_logic windowed_watchdog_arm_logic_i (.*);
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // slow count source, standing still unless a test enables it
    initial begin
        internalRcClk = 1'b0;
        forever #11 internalRcClk = srcOn & ~internalRcClk;
    end
    always @(posedge internalRcClk) ticks++;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 100000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        int   n;
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        n = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(aw && w) && n < 40);
        do begin
            @(posedge sys_clk);
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 40);
        if (n >= 40) error_cnt++;
    endtask : wr
    task automatic rd(input logic [9:0] a, output logic [31:0] d);
        int n;
        n = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (s_axi_arready !== 1'b1 && n < 40);
        s_axi_arvalid <= 1'b0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 40);
        d = s_axi_rdata;
        rsp = s_axi_rresp;
        if (n >= 40) error_cnt++;
    endtask : rd
    // control write mirrored in the model, then read back
    task automatic ctl(input logic [7:0] d);
        wr(A_CTL, d);
        mCtl[6] = specialMode ? d[6] : (mCtl[6] | d[6]);
        if (!d[5] && (specialMode || !mOnce)) begin
            mOnce = 1'b1;
            if (specialMode || d[2:0] != 3'h0) mCtl[2:0] = d[2:0];
            mCtl[7] = specialMode ? d[7] : (mCtl[7] | d[7]);
        end
        rd(A_CTL, rdV);
        chk(rdV, {24'h0, mCtl});
    endtask : ctl
    task automatic key(input logic [7:0] d, input logic trip);
        logic seen;
        wr(A_KEY, d);
        seen = systemReset;
        repeat (3) begin
            @(posedge sys_clk);
            seen |= systemReset;
        end
        chk({31'h0, seen}, {31'h0, trip});
    endtask : key
    task automatic rst();
        reset <= 1'b1;
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        mCtl = 8'h00;
        mOnce = 1'b0;
        @(posedge sys_clk);
    endtask : rst
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    initial begin
        seed = 32'hc906;
        {reset, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, srcOn, specialMode, debugActive} = '0;
        {crystalOscClk, watchdogClkSel, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
        rst();
        rd(A_CTL, rdV);
        chk(rdV, 32'h0);
        rd(A_KEY, rdV);
        chk(rdV, 32'h0);
        rd(10'h140, rdV);
        chk({30'h0, rsp}, {30'h0, wdog_pkg::RESP_SLVERR});
        key(8'h12, 1'b0);
        wr(A_T0, 8'h5A);
        rd(A_T0, rdV);
        chk(rdV, 32'h0);
        specialMode <= 1'b1;
        wr(A_T0, 8'hA5);
        rd(A_T0, rdV);
        chk(rdV, 32'hA5);
        specialMode <= 1'b0;
        $display("test 1 done");
        ctl(8'h23);
        ctl(8'h40);
        ctl(8'h01);
        ctl(8'h00);
        debugActive <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({31'h0, tickTimerHalt}, 32'h1);
        debugActive <= 1'b0;
        $display("test 2 done");
        rst();
        ctl(8'h01);
        key(8'h55, 1'b0);
        rd(A_ST, rdV);
        chk(rdV, 32'h3);
        key(8'h55, 1'b0);
        key(8'hAA, 1'b0);
        rd(A_ST, rdV);
        chk(rdV, 32'h1);
        key(8'hAA, 1'b0);
        key(8'h55, 1'b0);
        watchdogClkSel <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd(A_ST, rdV);
        chk(rdV, 32'h1);
        watchdogClkSel <= 1'b0;
        rv = $random(seed);
        key({2'h3, rv[5:0]}, 1'b1);
        $display("test 3 done");
        rst();
        specialMode <= 1'b1;
        ctl(8'h81);
        ctl(8'h83);
        key(8'h55, 1'b1);
        rst();
        debugActive <= 1'b1;
        ctl(8'h81);
        key(8'h55, 1'b0);
        key(8'hAA, 1'b0);
        rv = $random(seed);
        key({2'h3, rv[5:0]}, 1'b1);
        $display("test 4 done");
        rst();
        specialMode <= 1'b0;
        debugActive <= 1'b0;
        ctl(8'h01);
        ticks = 0;
        srcOn = 1'b1;
        while (systemReset !== 1'b1 && ticks < PER1 + 600) @(posedge sys_clk);
        srcOn = 1'b0;
        chk({31'h0, ticks >= PER1 - 4 && ticks <= PER1 + 4}, 32'h1);
        $display("test 5 done");
        stop_test();
    end
endmodule : test_windowed_watchdog_arm_logic
bind windowed_watchdog_arm_logic wdog_chk chk_i (.*);
